// ==== rtl/sar_seq_defs.svh ====
// Purpose: Constants for the successive approximation conversion sequencer
// Assumes: System clock of 40 MHz (25 ns period)
// Notes:   Times are in nanoseconds; cycle counts derive from them
`ifndef SAR_SEQ_DEFS_SVH
`define SAR_SEQ_DEFS_SVH

`define SAR_CLK_PERIOD_NS 25
`define SAR_RES_BITS 12
`define SAR_STEPS 13
// Internal clock near 1.9 MHz: 526 ns period
`define SAR_BIT_PERIOD_NS 526
// Post-decision delay before the busy flag falls
`define SAR_FLAG_DELAY_NS 40
// Least times round up to whole system cycles
`define SAR_BIT_CYCLES \
  ((`SAR_BIT_PERIOD_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_DELAY_CYCLES \
  ((`SAR_FLAG_DELAY_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_RESULT_RST 12'hfff

`endif

// ==== rtl/sar_seq_pkg.sv ====
// Purpose: Types for the successive approximation conversion sequencer
// Assumes: Nothing beyond the constants header
// Notes:   Result word carries code and its inverted top bit
package sar_seq_pkg;

  typedef enum logic [1:0] {
    st_idle,
    st_arm,
    st_run,
    st_hold
  } seq_state_type;

  // Parallel result group, negative-true
  typedef struct packed {
    logic [11:0] code;
    logic msb_inv;
  } result_type;

endpackage

// ==== rtl/sar_bit_timer.sv ====
// Purpose: Gated internal conversion clock
// Assumes: Enable held high for the whole conversion
// Notes:   Output low while gated off; tick marks each rising edge
`timescale 1ns/1ps
module sar_bit_timer #(
  parameter int PERIOD = 22 // System cycles per internal clock period
) (
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_run, // Removes the clock inhibit
  output logic o_tick, // One-cycle pulse at internal rising edge
  output logic o_clk // Gated internal clock, low when idle
);

  localparam int CW = $clog2(PERIOD + 1);

  initial begin
    if (PERIOD < 2) begin
      $error("sar_bit_timer: PERIOD must be at least 2");
    end
  end

  logic [CW-1:0] cnt_ff;
  logic clk_ff;

  // Period counter restarts whenever the inhibit is applied
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_ff <= '0;
    end else if (!i_run || cnt_ff == CW'(PERIOD - 1)) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

  // High during the first half of each period, low when inhibited
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      clk_ff <= 1'b0;
    end else begin
      clk_ff <= i_run && (cnt_ff < CW'(PERIOD / 2));
    end
  end

  assign o_tick = i_run && cnt_ff == '0;
  assign o_clk = clk_ff;

endmodule // sar_bit_timer

// ==== rtl/sar_conversion_sequencer.sv ====
// Purpose: Control logic of a 12-bit successive approximation converter
// Assumes: Convert pulse synchronous to i_clk; comparator sampled directly
// Notes:   Results are negative-true; busy falls a fixed delay after
//          the last decision so the host can latch on its falling edge
`timescale 1ns/1ps
`include "sar_seq_defs.svh"

module sar_conversion_sequencer
  import sar_seq_pkg::*;
#(
  parameter int BITS = `SAR_RES_BITS, // Result width
  parameter int BIT_CYCLES = `SAR_BIT_CYCLES, // Internal clock period
  parameter int DELAY_CYCLES = `SAR_DELAY_CYCLES // Post-decision delay
) (
  input wire logic i_clk, // System clock, 40 MHz
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_convert, // Convert command, positive pulse
  input wire logic i_comp_high, // Comparator: input above feedback level
  input wire logic [3:0] i_short_bits, // Bits to convert, 0 means all
  output logic o_busy, // High while converting
  output logic o_int_clk, // Gated internal clock
  output logic [BITS-1:0] o_dac_code, // Feedback converter inputs
  output sar_seq_pkg::result_type o_result // Negative-true result
);

  import sar_seq_pkg::*;

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  initial begin
    if (BITS != 12) begin
      $error("sar_conversion_sequencer: BITS must be 12");
    end
    if (BIT_CYCLES < 2 || DELAY_CYCLES < 1) begin
      $error("sar_conversion_sequencer: timing counts too small");
    end
  end

  localparam int DW = $clog2(DELAY_CYCLES + 1);

  seq_state_type state_ff;
  logic conv_d_ff;
  logic [BITS-1:0] sar_ff;
  logic [3:0] step_ff;
  logic [DW-1:0] dly_ff;
  logic busy_ff;
  logic tick;
  logic conv_fall;
  logic [3:0] last_step;

  // Trailing edge of the convert command starts a conversion
  assign conv_fall = conv_d_ff && !i_convert;

  // Short cycle selects the step of the final decision
  assign last_step = (i_short_bits == 4'h0 || i_short_bits > 4'hc)
                     ? 4'hc : i_short_bits;

  // ------------------------------------------------------------
  // Gated internal clock
  // ------------------------------------------------------------
  sar_bit_timer #(
    .PERIOD(BIT_CYCLES)
  ) u_timer (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_run(state_ff == st_run),
    .o_tick(tick),
    .o_clk(o_int_clk)
  );

  // ------------------------------------------------------------
  // Command edge detect
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      conv_d_ff <= 1'b0;
    end else begin
      conv_d_ff <= i_convert;
    end
  end

  // ------------------------------------------------------------
  // Sequence control
  // ------------------------------------------------------------
  // Command arms, trailing edge runs, last decision waits the delay
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= st_idle;
    end else if (conv_fall) begin
      state_ff <= st_run;
    end else begin
      case (state_ff)
        st_idle: begin
          if (i_convert) begin
            state_ff <= st_arm;
          end
        end
        st_arm: begin
          state_ff <= st_arm;
        end
        st_run: begin
          if (tick && step_ff == last_step) begin
            state_ff <= st_hold;
          end
        end
        st_hold: begin
          if (dly_ff == DW'(DELAY_CYCLES - 1)) begin
            state_ff <= st_idle;
          end
        end
        default: begin
          state_ff <= st_idle;
        end
      endcase
    end
  end

  // Step counter, one step per internal clock rising edge
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      step_ff <= 4'h0;
    end else if (conv_fall) begin
      step_ff <= 4'h0;
    end else if (state_ff == st_run && tick) begin
      step_ff <= step_ff + 4'h1;
    end
  end

  // Post-decision delay counter
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dly_ff <= '0;
    end else if (state_ff == st_hold) begin
      dly_ff <= dly_ff + DW'(1);
    end else begin
      dly_ff <= '0;
    end
  end

  // Busy flag: high from command until the delay expires; a command
  // seen in the final delay cycle wins over the clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= i_convert || (state_ff != st_idle
        && !(state_ff == st_hold && dly_ff == DW'(DELAY_CYCLES - 1)));
    end
  end

  // ------------------------------------------------------------
  // Approximation register
  // ------------------------------------------------------------
  // Stored negative-true: a 0 means the bit is kept
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sar_ff <= `SAR_RESULT_RST;
    end else if (conv_fall) begin
      sar_ff <= `SAR_RESULT_RST;
    end else if (state_ff == st_run && tick) begin
      for (int n = 0; n < BITS; n++) begin
        if (step_ff == 4'h0) begin
          // Try top bit (active low), others off
          sar_ff[n] <= (n == BITS - 1) ? 1'b0 : 1'b1;
        end else if (n == BITS - int'(step_ff)) begin
          // Keep when input is above the trial level
          sar_ff[n] <= !i_comp_high;
        end else if (n == BITS - 1 - int'(step_ff)) begin
          sar_ff[n] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_busy = busy_ff;
  assign o_dac_code = ~sar_ff;
  assign o_result.code = sar_ff;
  assign o_result.msb_inv = ~sar_ff[BITS-1];

endmodule // sar_conversion_sequencer

// ==== dv/sar_seq_properties.sv ====
// Purpose: Timing checks for the conversion sequencer
// Assumes: Only the sequencer's own ports are seen
// Notes: Counters track busy length and clock edges
`timescale 1ns/1ps
module sar_seq_properties
  import sar_seq_pkg::*;
#(
  parameter int BIT_CYCLES = 22, // Internal clock period
  parameter int DELAY_CYCLES = 2 // Post-decision delay
) (
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Reset, active low
  input wire logic i_convert, // Convert command
  input wire logic i_comp_high, // Comparator
  input wire logic [3:0] i_short_bits, // Bit count
  input wire logic o_busy, // Busy flag
  input wire logic o_int_clk, // Gated clock
  input wire logic [11:0] o_dac_code, // Feedback code
  input wire sar_seq_pkg::result_type o_result // Result
);
  int cyc_ff;
  int edg_ff;
  int nb;
  logic clk_d_ff;
  // Bits to convert and the least busy length
  assign nb = (i_short_bits == 4'h0 || i_short_bits > 4'hc) ?
    12 : int'(i_short_bits);
  // Count busy cycles after the pulse and clock rises
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cyc_ff <= 0;
      edg_ff <= 0;
      clk_d_ff <= 1'b0;
    end else begin
      cyc_ff <= !o_busy ? 0 : cyc_ff + int'(!i_convert);
      edg_ff <= !o_busy ? 0 : edg_ff + int'(o_int_clk && !clk_d_ff);
      clk_d_ff <= o_int_clk;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  busy_set_a: assert property (
    $rose(i_convert) && !o_busy |=> o_busy) else $error("busy late");
  busy_len_a: assert property (
    $fell(o_busy) |-> cyc_ff > nb * BIT_CYCLES + DELAY_CYCLES &&
    cyc_ff <= nb * BIT_CYCLES + DELAY_CYCLES + 5) else $error("busy len");
  clk_edges_a: assert property (
    $fell(o_busy) |-> edg_ff == nb + 1) else $error("clock edges");
  clk_idle_a: assert property (
    !o_busy && !$fell(o_busy) |-> !o_int_clk) else $error("clock idle");
  dac_mirror_a: assert property (
    o_dac_code == ~o_result.code) else $error("dac code");
  msb_inv_a: assert property (
    o_result.msb_inv == ~o_result.code[11]) else $error("msb inv");
  reg_init_a: assert property (
    $fell(i_convert) |-> ##[1:2] o_result.code == 12'hfff)
    else $error("init");
  first_step_a: assert property (
    $fell(i_convert) |-> ##[2:4] o_result.code == 12'h7ff)
    else $error("step zero");
  one_step_a: assert property (
    o_busy && $changed(o_result.code) |-> o_result.code == 12'hfff ||
    $countones(o_result.code ^ $past(o_result.code)) <= 2)
    else $error("step");
  idle_hold_a: assert property (
    !o_busy |-> $stable(o_result.code)) else $error("hold");
  // A decision raises a code bit exactly when the comparator was low
  keep_drop_a: assert property (
    o_busy && $changed(o_result.code) && o_result.code != 12'hfff &&
    $past(o_result.code) != 12'hfff |->
    ((o_result.code & ~$past(o_result.code)) != 12'h000) ==
    !$past(i_comp_high)) else $error("keep drop");
endmodule // sar_seq_properties
bind sar_conversion_sequencer sar_seq_properties #(
  .BIT_CYCLES(BIT_CYCLES), .DELAY_CYCLES(DELAY_CYCLES)
) sar_seq_properties_inst (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_convert(i_convert), .i_comp_high(i_comp_high),
  .i_short_bits(i_short_bits), .o_busy(o_busy), .o_int_clk(o_int_clk),
  .o_dac_code(o_dac_code), .o_result(o_result));

// ==== dv/sar_host_model.sv ====
// Purpose: Host and comparator beside the sequencer
// Assumes: Start and target change at the falling edge
// Notes: Result latched on the falling busy edge
`timescale 1ns/1ps
module sar_host_model
  import sar_seq_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Reset, active low
  input wire logic i_start, // Request one conversion
  input wire logic [11:0] i_target, // Analog level
  input wire logic [11:0] i_dac_code, // Trial level
  input wire logic i_busy, // Busy flag
  input wire result_type i_result, // Result outputs
  output logic o_convert, // Convert pulse
  output logic o_comp_high, // Comparator
  output result_type o_latched // Latched result
);
  logic [2:0] cnt_ff = 3'h0;
  initial o_convert = 1'b0;
  // Four cycle pulse, then low for the run
  always @(negedge i_clk) begin
    cnt_ff <= i_start ? 3'h4 : cnt_ff - 3'(cnt_ff != 3'h0);
    o_convert <= i_start || cnt_ff > 3'h1;
  end
  // Keep a bit while the input reaches the trial
  assign o_comp_high = i_target >= i_dac_code;
  // Latch result as busy falls
  always @(negedge i_busy) begin
    if (i_rstn === 1'b1) o_latched <= i_result;
  end
endmodule // sar_host_model

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench of the sequencer
// Assumes: Short internal clock period of 4 cycles
// Notes: Driver queues codes, monitor checks latches
`timescale 1ns/1ps
module testbench;
  import sar_seq_pkg::*;
  logic i_clk = 1'b0, i_rstn = 1'b0, start = 1'b0, conv, comp, busy, iclk;
  logic [3:0] sbits = 4'h0;
  logic [11:0] target = 12'h000, dac, e;
  result_type res, lat;
  int err_count = 0, checks = 0;
  logic [11:0] exp_q[$];
  logic [11:0] tv[4] = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
  logic [3:0] sv[8] = '{4'h0, 4'hc, 4'hd, 4'hf, 4'h1, 4'h8, 4'ha, 4'hb};
  initial forever #12.5 i_clk = ~i_clk;
  sar_conversion_sequencer #(.BIT_CYCLES(4)) sar_conversion_sequencer_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_convert(conv), .i_comp_high(comp),
    .i_short_bits(sbits), .o_busy(busy), .o_int_clk(iclk),
    .o_dac_code(dac), .o_result(res));
  sar_host_model sar_host_model_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_start(start), .i_target(target), .i_dac_code(dac), .i_busy(busy),
    .i_result(res), .o_convert(conv), .o_comp_high(comp), .o_latched(lat));
  task stop_test;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input string nm, input logic [11:0] ex, input logic [11:0] sn);
    checks++;
    if (sn !== ex) begin
      $display("mismatch %s exp %h seen %h", nm, ex, sn);
      err_count++;
    end
  endtask
  task convert_one(input logic [11:0] t, input logic [3:0] sb);
    int n;
    logic [11:0] x;
    n = (sb == 4'h0 || sb > 4'hc) ? 12 : int'(sb);
    x = 12'hfff;
    for (int i = 0; i < 12; i++) begin
      if (i >= 12 - n) x[i] = ~t[i];
      else if (i == 11 - n) x[i] = 1'b0;
    end
    exp_q.push_back(x);
    @(negedge i_clk);
    target <= t;
    sbits <= sb;
    start <= 1'b1;
    @(negedge i_clk);
    start <= 1'b0;
    repeat (8) @(negedge i_clk);
    for (int k = 0; k < 200 && busy !== 1'b0; k++) @(negedge i_clk);
    repeat (2) @(negedge i_clk);
  endtask
  // Monitor compares each latched result with the oldest note
  always @(negedge busy) begin
    if (i_rstn === 1'b1) begin
      #1;
      e = exp_q.size() ? exp_q.pop_front() : 12'hxxx;
      check("code", e, lat.code);
      check("msb_inv", {11'h0, ~e[11]}, {11'h0, lat.msb_inv});
    end
  end
  // Watchdog cuts a hang short
  initial begin
    #(25 * 10000);
    err_count++;
    stop_test();
  end
  initial begin
    void'($urandom(82035));
    repeat (10) @(negedge i_clk);
    i_rstn <= 1'b1;
    for (int i = 0; i < 16; i++)
      convert_one(i < 4 ? tv[i] : 12'($urandom()),
        i < 8 ? sv[i] : 4'($urandom()));
    @(negedge i_clk);
    start <= 1'b1;
    @(negedge i_clk);
    start <= 1'b0;
    repeat (20) @(negedge i_clk);
    i_rstn <= 1'b0;
    @(negedge i_clk);
    check("busy", 12'h000, {11'h0, busy});
    check("reset code", 12'hfff, res.code);
    check("reset dac", 12'h000, dac);
    check("reset clk", 12'h000, {11'h0, iclk});
    i_rstn <= 1'b1;
    convert_one(12'($urandom()), 4'hc);
    check("queue", 12'h000, 12'(exp_q.size()));
    stop_test();
  end
endmodule // testbench
